// file: design/ascr_host.sv
// Our own choices: the AHB-Lite slave port and the placing of the registers.
module ascr_host (
    input wire logic core_clk_i,
    input wire logic rst_i,
    ascr_if.host link,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o
);

    typedef struct packed {
        ascr_pkg::ascr_host_state_t state;
        logic [ascr_pkg::DIV_W-1:0] div;
        logic ph;
        logic [ascr_pkg::BITC_W-1:0] bitc;
        logic [ascr_pkg::SETUP_W-1:0] cfg_sh;
        logic [ascr_pkg::SETUP_W-1:0] setup;
        logic [ascr_pkg::CTRL_W-1:0] ctrl;
        logic rd_req;
        logic [ascr_pkg::RESULT_W-1:0] res_sh;
        logic [ascr_pkg::RESULT_W-1:0] result;
        logic new_flag;
        logic sdo_s1;
        logic sdo_s2;
        logic busy_s1;
        logic busy_s2;
        logic busy_prev;
        logic sel_n;
        logic cclk;
        logic cdin;
        logic sclk;
        logic scs_n;
        logic a_wr;
        logic [ascr_pkg::ADDR_W-1:0] a_addr;
        logic [31:0] hrdata;
    } ascr_host_st_t;

    ascr_host_st_t q;
    ascr_host_st_t d;

    logic take;
    logic rd_set;
    logic wr_setup;
    logic half_done;
    logic inv;
    logic [ascr_pkg::ADDR_W-1:0] addr;

    always_comb begin
        d = q;
        inv = q.ctrl[ascr_pkg::CTRL_INV];
        addr = haddr_i[ascr_pkg::ADDR_W-1:0];
        d.sdo_s1 = link.sd_out;
        d.sdo_s2 = q.sdo_s1;
        d.busy_s1 = link.busy;
        d.busy_s2 = q.busy_s1;
        d.busy_prev = q.busy_s2;
        // End of conversion queues a read when enabled [RL9]
        rd_set = q.ctrl[ascr_pkg::CTRL_AUTO] & q.busy_prev & ~q.busy_s2;

        // Data phase of a write
        wr_setup = 1'b0;
        if (q.a_wr) begin
            if (q.a_addr == ascr_pkg::OFS_SETUP) begin
                wr_setup = (q.state == ascr_pkg::H_IDLE);
                if (wr_setup) begin
                    d.setup = hwdata_i[ascr_pkg::SETUP_W-1:0];
                    d.setup[ascr_pkg::START_BIT] = 1'b1;
                end
            end else if (q.a_addr == ascr_pkg::OFS_CTRL) begin
                d.ctrl = hwdata_i[ascr_pkg::CTRL_W-1:0];
            end else if (q.a_addr == ascr_pkg::OFS_CMD) begin
                rd_set = rd_set | hwdata_i[ascr_pkg::CMD_READ];
            end else if (q.a_addr == ascr_pkg::OFS_STATUS) begin
                if (hwdata_i[ascr_pkg::ST_NEW]) begin
                    d.new_flag = 1'b0;
                end
            end
        end

        // Divider for the link clocks [RL11]
        half_done = (q.div == ascr_pkg::DIV_LAST);
        d.div = half_done ? '0 : q.div + 1'b1;

        case (q.state)
            ascr_pkg::H_IDLE: begin
                d.div = '0;
                d.ph = 1'b0;
                d.bitc = '0;
                d.cclk = inv;
                d.sclk = 1'b0;
                if (wr_setup) begin
                    // Start bit goes out first, MSB first [RL12]
                    d.state = ascr_pkg::H_CFG;
                    d.sel_n = 1'b0;
                    d.cfg_sh = d.setup;
                    d.cdin = d.setup[ascr_pkg::START_BIT]; // [RL1]
                end else if (q.rd_req && !q.busy_s2) begin
                    // Read only once conversion is over [RL8]
                    d.state = ascr_pkg::H_READ;
                    d.rd_req = 1'b0;
                    d.scs_n = 1'b0;
                end
            end
            ascr_pkg::H_CFG: begin
                if (half_done) begin
                    d.ph = ~q.ph;
                    if (!q.ph) begin
                        d.cclk = ~inv;
                    end else begin
                        d.cclk = inv;
                        if (q.bitc == ascr_pkg::CFG_LAST) begin
                            d.sel_n = 1'b1;
                            d.state = ascr_pkg::H_IDLE;
                        end else begin
                            d.bitc = q.bitc + 1'b1;
                            d.cfg_sh = {q.cfg_sh[ascr_pkg::SETUP_W-2:0],
                                1'b0};
                            d.cdin = q.cfg_sh[ascr_pkg::SETUP_W-2];
                        end
                    end
                end
            end
            ascr_pkg::H_READ: begin
                if (half_done) begin
                    d.ph = ~q.ph;
                    if (!q.ph) begin
                        d.sclk = 1'b1; // [RL10]
                    end else begin
                        // Idle low, sample on falling edge [RL10]
                        d.sclk = 1'b0;
                        d.res_sh = {q.res_sh[ascr_pkg::RESULT_W-2:0],
                            q.sdo_s2};
                        if (q.bitc == ascr_pkg::RD_LAST) begin
                            d.result = {q.res_sh[ascr_pkg::RESULT_W-2:0],
                                q.sdo_s2};
                            d.new_flag = 1'b1;
                            d.scs_n = 1'b1;
                            d.state = ascr_pkg::H_IDLE;
                        end else begin
                            d.bitc = q.bitc + 1'b1;
                        end
                    end
                end
            end
            default: begin
                d.state = ascr_pkg::H_IDLE;
            end
        endcase

        // A request in the cycle a read starts stays pending
        if (rd_set) begin
            d.rd_req = 1'b1;
        end

        // Address phase
        take = hsel_i & htrans_i[ascr_pkg::HTRANS_ACT] & hready_i;
        d.a_wr = take & hwrite_i;
        d.a_addr = take ? addr : q.a_addr;
        if (take && !hwrite_i) begin
            d.hrdata = '0;
            if (addr == ascr_pkg::OFS_SETUP) begin
                d.hrdata[ascr_pkg::SETUP_W-1:0] = q.setup;
            end else if (addr == ascr_pkg::OFS_CTRL) begin
                d.hrdata[ascr_pkg::CTRL_W-1:0] = q.ctrl;
            end else if (addr == ascr_pkg::OFS_STATUS) begin
                d.hrdata[ascr_pkg::ST_CFG] = (q.state == ascr_pkg::H_CFG);
                d.hrdata[ascr_pkg::ST_RD] = (q.state == ascr_pkg::H_READ);
                d.hrdata[ascr_pkg::ST_BUSY] = q.busy_s2;
                d.hrdata[ascr_pkg::ST_NEW] = q.new_flag;
                d.hrdata[ascr_pkg::ST_REQ] = q.rd_req;
            end else if (addr == ascr_pkg::OFS_RESULT) begin
                d.hrdata[ascr_pkg::RESULT_W-1:0] = q.result;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.state <= ascr_pkg::H_IDLE;
            q.sel_n <= 1'b1;
            q.scs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hrdata_o = q.hrdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = ascr_pkg::HRESP_OKAY;
    assign link.cfg_port_select_n = q.sel_n;
    assign link.cfg_port_clock = q.cclk;
    assign link.cfg_port_serial_in = q.cdin;
    assign link.clock_invert_sel = inv;
    assign link.sd_clk = q.sclk;
    assign link.sd_cs_n = q.scs_n;

endmodule

// file: pkg/ascr_pkg.sv
package ascr_pkg;
    // Setup word layout
    localparam int SETUP_W = 9;
    localparam int RESULT_W = 16;
    localparam int START_BIT = 8;
    localparam int RANGE_HI = 7;
    localparam int RANGE_LO = 6;
    localparam int PD_BIT = 5;
    localparam int MODE_HI = 4;
    localparam int MODE_LO = 3;
    localparam int CODING_BIT = 2;
    localparam int RSV_HI = 1;
    localparam logic [SETUP_W-1:0] SETUP_RST = 9'h000;

    // Edges that follow the start bit within one frame
    localparam int CNT_W = 4;
    localparam int LOAD_EDGES = 8;
    localparam logic [CNT_W-1:0] LOAD_LAST = CNT_W'(LOAD_EDGES);
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SPI_MAX_BPS = 17_000_000;
    localparam int SPI_HALF_NS = 160;
    localparam int HALF_BY_TIME =
        (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_BY_RATE =
        (CLK_HZ + 2 * SPI_MAX_BPS - 1) / (2 * SPI_MAX_BPS);
    localparam int SCK_HALF_CYC =
        (HALF_BY_TIME > HALF_BY_RATE) ? HALF_BY_TIME : HALF_BY_RATE;
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
    localparam int BITC_W = 5;
    localparam logic [BITC_W-1:0] CFG_LAST = BITC_W'(SETUP_W - 1);
    localparam logic [BITC_W-1:0] RD_LAST = BITC_W'(RESULT_W - 1);

    // Host register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_SETUP = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h10;
    localparam int CTRL_W = 2;
    localparam int CTRL_AUTO = 0;
    localparam int CTRL_INV = 1;
    localparam int CMD_READ = 0;
    localparam int ST_CFG = 0;
    localparam int ST_RD = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_NEW = 3;
    localparam int ST_REQ = 4;
    localparam int HTRANS_ACT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    // Device pin synchroniser slots
    localparam int SY_SEL = 0;
    localparam int SY_CCLK = 1;
    localparam int SY_CDIN = 2;
    localparam int SY_INV = 3;
    localparam int SY_SCLK = 4;
    localparam int SY_SCS = 5;
    localparam int SY_DAISY = 6;
    localparam int SY_SERPAR = 7;
    localparam int SY_SELA = 8;
    localparam int SY_W = 9;

    typedef enum logic [1:0] {
        RANGE_0_5 = 2'b00,
        RANGE_0_10 = 2'b01,
        RANGE_PM5 = 2'b10,
        RANGE_PM10 = 2'b11
    } ascr_range_t;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SCALED = 2'b01,
        MODE_FAST = 2'b10
    } ascr_mode_t;

    typedef enum logic [1:0] {
        CFG_IDLE = 2'b01,
        CFG_LOAD = 2'b10
    } ascr_cfg_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_CFG = 3'b010,
        H_READ = 3'b100
    } ascr_host_state_t;
endpackage

// file: pkg/ascr_if.sv
interface ascr_if;
    logic cfg_port_select_n;
    logic cfg_port_clock;
    logic cfg_port_serial_in;
    logic clock_invert_sel;
    logic sd_clk;
    logic sd_cs_n;
    logic sd_out;
    logic busy;

    modport dev (
        input cfg_port_select_n,
        input cfg_port_clock,
        input cfg_port_serial_in,
        input clock_invert_sel,
        input sd_clk,
        input sd_cs_n,
        output sd_out,
        output busy
    );

    modport host (
        output cfg_port_select_n,
        output cfg_port_clock,
        output cfg_port_serial_in,
        output clock_invert_sel,
        output sd_clk,
        output sd_cs_n,
        input sd_out,
        input busy
    );
endinterface

// file: design/ascr_dev.sv
// Operation
// [RL1] Start bit high begins load on active edge
// [RL2] Bits 7:6 pick 0-5V, 0-10V, +-5V ranges
// [RL3] Bits 7:6 both high pick +-10V
// [RL4] Bit 5 powers down; port still writable
// [RL5] Host clears bit 5 to power up
// [RL6] Bits 4:3 pick normal, scaled, fast mode
// [RL7] Bit 2 picks twos complement or binary
// [RL8] Device is slave; read after conversion; chainable
// [RL9] Host may start read on busy fall
// [RL10] Host reads with polarity 0, phase 1
// [RL11] Host limits read clock to 17 Mbps
// [RL12] Shift MSB first; ninth edge commits word
// [RL13] Reserved bits 1:0 are never written
// [RL14] Reset clears whole setup word
// [RL15] Port works only in serial software mode
module ascr_dev (
    input wire logic core_clk_i,
    input wire logic rst_i,
    ascr_if.dev link,
    input wire logic serial_parallel_sel_i,
    input wire logic cfg_sel_a_i,
    input wire logic daisy_in_i,
    input wire logic conv_busy_i,
    input wire logic [ascr_pkg::RESULT_W-1:0] result_i,
    output logic [ascr_pkg::SETUP_W-1:0] setup_word_o,
    output ascr_pkg::ascr_range_t range_o,
    output logic power_down_ctl_o,
    output ascr_pkg::ascr_mode_t mode_o,
    output logic output_coding_sel_o,
    output logic port_enabled_o
);

    typedef struct packed {
        logic [ascr_pkg::SY_W-1:0] sync1;
        logic [ascr_pkg::SY_W-1:0] sync2;
        logic cclk_prev;
        logic sclk_prev;
        logic scs_prev;
        ascr_pkg::ascr_cfg_state_t state;
        logic [ascr_pkg::CNT_W-1:0] cnt;
        logic [ascr_pkg::LOAD_EDGES-1:0] nb;
        logic [ascr_pkg::SETUP_W-1:0] setup;
        ascr_pkg::ascr_range_t range;
        ascr_pkg::ascr_mode_t mode;
        logic enabled;
        logic conv_prev;
        logic busy;
        logic [ascr_pkg::RESULT_W-1:0] sh;
        logic sdout;
    } ascr_dev_st_t;

    ascr_dev_st_t q;
    ascr_dev_st_t d;

    logic [ascr_pkg::SY_W-1:0] pins;
    logic cclk;
    logic inv;
    logic sel_low;
    logic act_edge;
    logic sclk;
    logic sclk_rise;
    logic sclk_fall;
    logic rd_sel;
    logic [ascr_pkg::LOAD_EDGES-1:0] nb_next;
    logic [ascr_pkg::SETUP_W-1:0] next_setup;
    logic coding;

    always_comb begin
        pins = '0;
        pins[ascr_pkg::SY_SEL] = link.cfg_port_select_n;
        pins[ascr_pkg::SY_CCLK] = link.cfg_port_clock;
        pins[ascr_pkg::SY_CDIN] = link.cfg_port_serial_in;
        pins[ascr_pkg::SY_INV] = link.clock_invert_sel;
        pins[ascr_pkg::SY_SCLK] = link.sd_clk;
        pins[ascr_pkg::SY_SCS] = link.sd_cs_n;
        pins[ascr_pkg::SY_DAISY] = daisy_in_i;
        pins[ascr_pkg::SY_SERPAR] = serial_parallel_sel_i;
        pins[ascr_pkg::SY_SELA] = cfg_sel_a_i;
    end

    always_comb begin
        d = q;
        // Two-stage synchronisers for every pin
        d.sync1 = pins;
        d.sync2 = q.sync1;

        cclk = q.sync2[ascr_pkg::SY_CCLK];
        inv = q.sync2[ascr_pkg::SY_INV];
        sclk = q.sync2[ascr_pkg::SY_SCLK];
        d.cclk_prev = cclk;
        d.sclk_prev = sclk;
        d.scs_prev = q.sync2[ascr_pkg::SY_SCS];

        // Serial software mode only [RL15]
        d.enabled = q.sync2[ascr_pkg::SY_SERPAR]
            & ~q.sync2[ascr_pkg::SY_SELA];
        sel_low = ~q.sync2[ascr_pkg::SY_SEL] & q.enabled;

        // Rising edge normally, falling edge when inverted [RL1]
        act_edge = inv ? (q.cclk_prev & ~cclk) : (~q.cclk_prev & cclk);

        nb_next = {q.nb[ascr_pkg::LOAD_EDGES-2:0],
            q.sync2[ascr_pkg::SY_CDIN]};
        next_setup = q.setup;
        next_setup[ascr_pkg::START_BIT] = 1'b1;
        next_setup[ascr_pkg::RANGE_HI:ascr_pkg::CODING_BIT] =
            nb_next[ascr_pkg::RANGE_HI:ascr_pkg::CODING_BIT];
        // Reserved bits keep their value [RL13]
        next_setup[ascr_pkg::RSV_HI:0] = q.setup[ascr_pkg::RSV_HI:0];

        case (q.state)
            ascr_pkg::CFG_IDLE: begin
                if (sel_low && act_edge
                    && q.sync2[ascr_pkg::SY_CDIN]) begin
                    d.state = ascr_pkg::CFG_LOAD; // [RL1]
                    d.cnt = ascr_pkg::CNT_ONE;
                    d.nb = '0;
                end
            end
            ascr_pkg::CFG_LOAD: begin
                if (!sel_low) begin
                    d.state = ascr_pkg::CFG_IDLE;
                end else if (act_edge) begin
                    // MSB first behind the start bit [RL12]
                    d.nb = nb_next;
                    d.cnt = q.cnt + ascr_pkg::CNT_ONE;
                    if (q.cnt == ascr_pkg::LOAD_LAST) begin
                        // Ninth edge commits, also in power-down [RL12]
                        d.setup = next_setup; // [RL4]
                        d.state = ascr_pkg::CFG_IDLE;
                    end
                end
            end
            default: begin
                d.state = ascr_pkg::CFG_IDLE;
            end
        endcase

        // Input range decode [RL2]
        case (d.setup[ascr_pkg::RANGE_HI:ascr_pkg::RANGE_LO])
            2'b00: d.range = ascr_pkg::RANGE_0_5;
            2'b01: d.range = ascr_pkg::RANGE_0_10;
            2'b10: d.range = ascr_pkg::RANGE_PM5;
            default: d.range = ascr_pkg::RANGE_PM10; // [RL3]
        endcase

        // Conversion mode decode [RL6]
        case (d.setup[ascr_pkg::MODE_HI:ascr_pkg::MODE_LO])
            2'b10: d.mode = ascr_pkg::MODE_SCALED;
            2'b01: d.mode = ascr_pkg::MODE_FAST;
            default: d.mode = ascr_pkg::MODE_NORMAL;
        endcase

        // Busy follows the converter; result latched at its fall
        d.conv_prev = conv_busy_i;
        d.busy = conv_busy_i;
        coding = q.setup[ascr_pkg::CODING_BIT];

        sclk_rise = ~q.sclk_prev & sclk;
        sclk_fall = q.sclk_prev & ~sclk;
        // Held one cycle past deselect so the last fall still latches [RL8]
        rd_sel = ~(q.sync2[ascr_pkg::SY_SCS] & q.scs_prev);

        if (q.conv_prev && !conv_busy_i) begin
            // Straight binary or twos complement [RL7]
            d.sh = coding ? result_i
                : {~result_i[ascr_pkg::RESULT_W-1],
                   result_i[ascr_pkg::RESULT_W-2:0]};
        end else if (rd_sel && sclk_rise) begin
            // Slave launches on rising, host samples falling [RL8]
            d.sdout = q.sh[ascr_pkg::RESULT_W-1];
            d.sh = {q.sh[ascr_pkg::RESULT_W-2:0], 1'b0};
        end else if (rd_sel && sclk_fall) begin
            // Upstream data enters behind our own bits [RL8]
            d.sh[0] = q.sync2[ascr_pkg::SY_DAISY];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0; // [RL14]
            // Select pins wake at their idle high level
            q.sync1[ascr_pkg::SY_SEL] <= 1'b1;
            q.sync2[ascr_pkg::SY_SEL] <= 1'b1;
            q.sync1[ascr_pkg::SY_SCS] <= 1'b1;
            q.sync2[ascr_pkg::SY_SCS] <= 1'b1;
            q.scs_prev <= 1'b1;
            q.state <= ascr_pkg::CFG_IDLE;
            q.setup <= ascr_pkg::SETUP_RST; // [RL14]
            q.range <= ascr_pkg::RANGE_0_5;
            q.mode <= ascr_pkg::MODE_NORMAL;
        end else begin
            q <= d;
        end
    end

    // Setup outputs follow the committed word
    assign setup_word_o = q.setup;
    assign range_o = q.range;
    assign power_down_ctl_o = q.setup[ascr_pkg::PD_BIT]; // [RL4]
    assign mode_o = q.mode;
    assign output_coding_sel_o = q.setup[ascr_pkg::CODING_BIT];
    assign port_enabled_o = q.enabled;
    assign link.sd_out = q.sdout;
    assign link.busy = q.busy;

endmodule

// file: bench/ascr_checker.sv
module ascr_checker (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cfg_port_select_n,
    input wire logic cfg_port_clock,
    input wire logic cfg_port_serial_in,
    input wire logic clock_invert_sel,
    input wire logic sd_clk,
    input wire logic sd_cs_n,
    input wire logic sd_out,
    input wire logic busy
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    AST_START_HIGH: assert property (
        $fell(cfg_port_select_n) |-> cfg_port_serial_in)
        else $error("frame opens without start bit");
    AST_START_IDLE: assert property (
        $fell(cfg_port_select_n) |-> cfg_port_clock == clock_invert_sel)
        else $error("frame opens with clock not idle");
    AST_CFG_LEN: assert property (
        $fell(cfg_port_select_n)
        |-> ##143 !cfg_port_select_n ##1 cfg_port_select_n)
        else $error("setup frame length wrong");
    AST_CFG_DATA: assert property (
        (!cfg_port_select_n && !$past(cfg_port_select_n)
        && $changed(cfg_port_serial_in))
        |-> $changed(cfg_port_clock) && cfg_port_clock == clock_invert_sel)
        else $error("setup data moved off the inactive edge");
    AST_CFG_HALF: assert property (
        ($changed(cfg_port_clock) && !cfg_port_select_n)
        |=> $stable(cfg_port_clock)[*7])
        else $error("setup clock half period too short");
    AST_SD_IDLE: assert property (
        sd_cs_n |-> !sd_clk)
        else $error("result clock not low while idle");
    AST_SD_PHASE: assert property (
        $fell(sd_cs_n) |-> !sd_clk[*8] ##1 sd_clk)
        else $error("first result clock rise misplaced");
    AST_SD_AFTER: assert property (
        $fell(sd_cs_n) |-> !busy)
        else $error("read started during conversion");
    AST_SD_LEN: assert property (
        $fell(sd_cs_n) |-> ##255 !sd_cs_n ##1 sd_cs_n)
        else $error("result read length wrong");
    AST_SD_HALF: assert property (
        $changed(sd_clk) |=> $stable(sd_clk)[*7])
        else $error("result clock half period too short");
    AST_SD_HOLD: assert property (
        (!sd_cs_n && $fell(sd_clk)) |-> $stable(sd_out))
        else $error("result bit moved at sampling edge");
endmodule

// file: bench/ascr_bench.sv
module ascr_bench;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic inv;
        logic [8:0] w;
        logic [1:0] rng;
        logic pd;
        logic [1:0] md;
        logic cod;
    } ascr_row_t;

    logic core_clk, rst, hwrite, hready, hresp, sp_sel, sel_a, conv_busy;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0] htrans;
    logic [15:0] result;
    logic [8:0] setup_word;
    logic pd, cod, pen, daisy;
    ascr_pkg::ascr_range_t rng_o;
    ascr_pkg::ascr_mode_t md_o;
    int num_errors, tests_run;
    // Setup word with expected range, power-down, mode and coding
    ascr_row_t rows [5] = '{
        '{1'b0, 9'h100, 2'h0, 1'b0, 2'h0, 1'b0},
        '{1'b0, 9'h073, 2'h1, 1'b1, 2'h1, 1'b0},
        '{1'b1, 9'h08c, 2'h2, 1'b0, 2'h2, 1'b1},
        '{1'b1, 9'h0fa, 2'h3, 1'b1, 2'h0, 1'b0},
        '{1'b0, 9'h005, 2'h0, 1'b0, 2'h0, 1'b1}
    };

    ascr_if link();
    ascr_dev u_ascr_dev (.core_clk_i(core_clk), .rst_i(rst), .link(link),
        .serial_parallel_sel_i(sp_sel), .cfg_sel_a_i(sel_a),
        .daisy_in_i(daisy), .conv_busy_i(conv_busy), .result_i(result),
        .setup_word_o(setup_word), .range_o(rng_o), .power_down_ctl_o(pd),
        .mode_o(md_o), .output_coding_sel_o(cod), .port_enabled_o(pen));
    ascr_host u_ascr_host (.core_clk_i(core_clk), .rst_i(rst), .link(link),
        .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp));
    ascr_checker u_ascr_checker (.core_clk_i(core_clk), .rst_i(rst),
        .cfg_port_select_n(link.cfg_port_select_n),
        .cfg_port_clock(link.cfg_port_clock),
        .cfg_port_serial_in(link.cfg_port_serial_in),
        .clock_invert_sel(link.clock_invert_sel), .sd_clk(link.sd_clk),
        .sd_cs_n(link.sd_cs_n), .sd_out(link.sd_out), .busy(link.busy));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic final_report;
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        num_errors++;
        $display("ERROR at %0t: %s", $time, m);
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail($sformatf("got %h expected %h", got, exp));
        end
    endtask

    task automatic chk_setup(input ascr_row_t r);
        tests_run++;
        if (setup_word !== {1'b1, r.w[7:2], 2'b00} || rng_o !== r.rng
            || pd !== r.pd || md_o !== r.md || cod !== r.cod) begin
            fail($sformatf("setup outputs wrong for word %h", r.w));
        end
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge core_clk);
        while (hready !== 1'b1) begin
            @(posedge core_clk);
            n++;
            if (n > 50) begin
                fail("bus ready timeout");
                final_report();
            end
        end
    endtask

    // One single-word transfer; read data lands in rdat
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rdat = hrdata;
    endtask

    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        ahb(1'b0, ascr_pkg::OFS_STATUS, 32'h0);
        while (rdat[b] !== v) begin
            ahb(1'b0, ascr_pkg::OFS_STATUS, 32'h0);
            n++;
            if (n > 400) begin
                fail("status wait timeout");
                final_report();
            end
        end
    endtask

    task automatic send_cfg(input ascr_row_t r);
        ahb(1'b1, ascr_pkg::OFS_CTRL, {30'h0, r.inv, 1'b0});
        ahb(1'b1, ascr_pkg::OFS_SETUP, {23'h0, r.w});
        poll(ascr_pkg::ST_CFG, 1'b1);
        poll(ascr_pkg::ST_CFG, 1'b0);
        repeat (8) @(posedge core_clk);
    endtask

    task automatic read_result(input logic au, input logic [15:0] v,
                               input logic [15:0] e);
        ahb(1'b1, ascr_pkg::OFS_CTRL, {31'h0, au});
        conv_busy <= 1'b1;
        result <= v;
        repeat (6) @(posedge core_clk);
        if (!au) begin
            ahb(1'b1, ascr_pkg::OFS_CMD, 32'h1);
        end
        ahb(1'b0, ascr_pkg::OFS_STATUS, 32'h0);
        chk32(rdat & 32'h16, {27'h0, ~au, 4'h4});
        conv_busy <= 1'b0;
        poll(ascr_pkg::ST_NEW, 1'b1);
        ahb(1'b0, ascr_pkg::OFS_RESULT, 32'h0);
        chk32(rdat, {16'h0, e});
        ahb(1'b1, ascr_pkg::OFS_STATUS, 32'h8);
        ahb(1'b0, ascr_pkg::OFS_STATUS, 32'h0);
        chk32(rdat & 32'h8, 32'h0);
    endtask

    task automatic reset_pulse;
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk32({17'h0, setup_word, rng_o, pd, md_o, cod}, 32'h0);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        $display("Test reset done at %0t", $time);
    endtask

    initial begin
        num_errors = 0;
        tests_run = 0;
        rst = 1'b1;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        sp_sel = 1'b1;
        sel_a = 1'b0;
        conv_busy = 1'b0;
        result = 16'h0;
        daisy = 1'b0;
        reset_pulse();
        ahb(1'b0, 8'h20, 32'h0);
        chk32(rdat, 32'h0);
        chk32({31'h0, hresp}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            send_cfg(rows[i]);
            chk_setup(rows[i]);
            ahb(1'b0, ascr_pkg::OFS_SETUP, 32'h0);
            chk32(rdat, {23'h0, 1'b1, rows[i].w[7:0]});
            $display("Test row %0d done at %0t", i, $time);
        end
        sel_a <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk32({31'h0, pen}, 32'h0);
        send_cfg(rows[2]);
        chk_setup(rows[4]);
        sel_a <= 1'b0;
        sp_sel <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk32({31'h0, pen}, 32'h0);
        sp_sel <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk32({31'h0, pen}, 32'h1);
        $display("Test port disable done at %0t", $time);
        send_cfg(rows[0]);
        read_result(1'b0, 16'hc3a5, 16'h43a5);
        send_cfg(rows[4]);
        read_result(1'b1, 16'h1234, 16'h1234);
        $display("Test result read done at %0t", $time);
        daisy <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            ahb(1'b1, ascr_pkg::OFS_CMD, 32'h1);
            poll(ascr_pkg::ST_NEW, 1'b1);
            ahb(1'b0, ascr_pkg::OFS_RESULT, 32'h0);
            chk32(rdat, (k == 0) ? 32'h0 : 32'hffff);
            ahb(1'b1, ascr_pkg::OFS_STATUS, 32'h8);
        end
        $display("Test daisy chain done at %0t", $time);
        reset_pulse();
        final_report();
    end
endmodule
